// *** hdl/clock_blocks.sv ***
`timescale 1ns/1ps
module clock_blocks (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Configuration and ticks
  clk_blk_if.blocks cb
);
  logic ext_prev_r;
  logic ext_rise;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= cb.ext_clk;
    end
  end

  assign ext_rise = cb.ext_clk && !ext_prev_r; // R15

  for (genvar b = 0; b < io_port_pkg::NCB; b++) begin : g_blk
    logic [io_port_pkg::DIVW-1:0] cnt_r;
    logic                         base;
    assign base       = cb.src_pin[b] ? ext_rise : 1'b1; // R14
    assign cb.tick[b] = base && (cnt_r == cb.div[b]); // R16
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        cnt_r <= '0;
      end else if (cb.tick[b]) begin
        cnt_r <= '0;
      end else if (base) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule : clock_blocks

// *** hdl/port_engine.sv ***
`timescale 1ns/1ps
module port_engine #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Pacing and pins
  input  wire logic         tick,
  input  wire logic [W-1:0] pin_in,
  input  wire logic         ready_in,
  output logic      [W-1:0] pin_val,
  output logic              strobe_out,
  output logic              event_out,
  // Core side
  port_ctrl_if.engine       ctl
);
  logic [W-1:0] shift_r;
  logic         shift_v_r;
  logic [W-1:0] xfer_r;
  logic         xfer_v_r;
  logic [15:0]  count_r;
  logic [15:0]  stamp_r;
  logic         cond_ok;
  logic         fire;
  logic         mv_out;
  logic         mv_in;
  logic         push;

  always_comb begin
    case (ctl.cond_mode)
      io_port_pkg::COND_EQ: cond_ok = (pin_in == ctl.cond_val); // R20
      io_port_pkg::COND_NE: cond_ok = (pin_in != ctl.cond_val); // R20
      default:              cond_ok = 1'b1;
    endcase
  end

  // Pin transfer only on the paced tick, held off by time, strobe, condition
  assign fire = ctl.enable && tick
             && (!ctl.timed || count_r == ctl.time_val) // R7
             && (!ctl.strobe_in_en || ready_in) // R17
             && (ctl.dir_out ? shift_v_r : (!shift_v_r && cond_ok)); // R3
  assign mv_out = ctl.enable && ctl.dir_out && !shift_v_r && xfer_v_r; // R6
  assign mv_in  = ctl.enable && !ctl.dir_out && shift_v_r
               && (!xfer_v_r || ctl.rd); // R6
  // Full transfer register refuses the word instead of stalling the bus
  assign push   = ctl.enable && ctl.dir_out && ctl.wr && !xfer_v_r; // R21

  always_ff @(posedge clock) begin
    if (!rst_n || !ctl.enable) begin
      count_r <= '0;
    end else if (tick) begin
      count_r <= count_r + 16'h0001; // R7
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !ctl.enable) begin
      shift_v_r <= 1'b0;
      shift_r   <= '0;
    end else if (fire && !ctl.dir_out) begin
      shift_v_r <= 1'b1;
      shift_r   <= pin_in; // R3
    end else if (fire) begin
      shift_v_r <= 1'b0;
    end else if (mv_out) begin
      shift_v_r <= 1'b1;
      shift_r   <= xfer_r;
    end else if (mv_in) begin
      shift_v_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !ctl.enable) begin
      xfer_v_r <= 1'b0;
      xfer_r   <= '0;
    end else if (mv_in) begin
      xfer_v_r <= 1'b1;
      xfer_r   <= shift_r;
    end else if (push) begin
      xfer_v_r <= 1'b1;
      xfer_r   <= ctl.wdata; // R13
    end else if (mv_out || (ctl.rd && !ctl.dir_out)) begin
      xfer_v_r <= 1'b0; // R21
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_val    <= '0;
      stamp_r    <= '0;
      strobe_out <= 1'b0;
      event_out  <= 1'b0;
    end else begin
      strobe_out <= fire && ctl.dir_out && ctl.strobe_out_en; // R17
      event_out  <= fire; // R19
      if (fire) begin
        stamp_r <= count_r; // R9
      end
      if (fire && ctl.dir_out) begin
        pin_val <= shift_r; // R3
      end
    end
  end

  assign ctl.rdata = xfer_r;
  assign ctl.empty = !xfer_v_r;
  assign ctl.full  = xfer_v_r;
  assign ctl.count = count_r; // R8
  assign ctl.stamp = stamp_r; // R9
endmodule : port_engine

// *** hdl/timed_shift_serializer_io_port.sv ***
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
// How it works
// R1 - Five ports: 1, 4, 8, 16, 32 pins
// R2 - Whole port is either input or output
// R3 - Drive pins, or sample, optionally waiting
// R4 - Every core access finishes in one cycle
// R5 - Open drain: zero pulls low, one floats
// R6 - Shift stage plus transfer register form FIFO
// R7 - Sixteen-bit counter schedules pin transfers
// R8 - Counter readable anytime, delays I/O
// R9 - Counter captured as timestamp per transfer
// R10 - Enabled link takes its pins from ports
// R11 - Narrower enabled port beats wider on pins
// R12 - Unshared wider port pins stay usable
// R13 - Port always moves its own width
// R14 - Six clock blocks, block 0 reference
// R15 - Single-pin port can source a block
// R16 - Optional divider on pin-sourced clock
// R17 - Ready-in strobe accepted, strobe out generated
// R18 - Reset attaches every port to block 0
// R19 - Pin events go to scheduler, no interrupts
// R20 - Wait on pins equal or unequal value
// R21 - Full or empty transfer register refuses access
module timed_shift_serializer_io_port (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Pins
  input  wire logic [31:0] pin_in,
  output logic      [31:0] pin_out,
  output logic      [31:0] pin_oe,
  // Strobes and scheduler events
  input  wire logic [4:0]  ready_in,
  output logic      [4:0]  strobe_out,
  output logic      [4:0]  event_out
);
  localparam int NP = io_port_pkg::NPORT;
  localparam int NC = io_port_pkg::NCB;

  logic [io_port_pkg::CFGW-1:0] ctrl_r [NP];
  logic [31:0]                  cond_r [NP];
  logic [15:0]                  time_r [NP];
  logic                         link_en_r;
  logic [NC-1:0]                cb_src_r;
  logic [io_port_pkg::DIVW-1:0] cb_div_r [NC];

  logic [io_port_pkg::SYNCW-1:0] s1_r;
  logic [io_port_pkg::SYNCW-1:0] s2_r;
  logic [io_port_pkg::SYNCW-1:0] s3_r;
  logic [io_port_pkg::SYNCW-1:0] stable_r;
  logic [31:0]                   pins_s;
  logic [4:0]                    ready_s;

  logic [3:0]  unit;
  logic [2:0]  rsel;
  logic [NP-1:0] wr_data;
  logic [NP-1:0] rd_data;
  logic [31:0] pdat [NP];
  logic [31:0] pval [NP];
  logic [15:0] pcnt [NP];
  logic [15:0] pstm [NP];
  logic [NP-1:0] pempty;
  logic [NP-1:0] pfull;
  logic [NC-1:0] tick;
  logic [31:0] out_c;
  logic [31:0] oe_c;

  assign unit = addr[6:3];
  assign rsel = addr[2:0];

  // Three stages; a change is believed only once stages two and three agree
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= {ready_in, pin_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  for (genvar i = 0; i < io_port_pkg::SYNCW; i++) begin : g_sync
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        stable_r[i] <= 1'b0;
      end else if (s2_r[i] == s3_r[i]) begin
        stable_r[i] <= s3_r[i];
      end
    end
  end

  assign pins_s  = stable_r[31:0];
  assign ready_s = stable_r[io_port_pkg::SYNCW-1:32];

  // Register writes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int k = 0; k < NP; k++) begin
        ctrl_r[k] <= io_port_pkg::CTRL_RESET; // R18
        cond_r[k] <= '0;
        time_r[k] <= '0;
      end
      link_en_r <= 1'b0;
    end else if (wr) begin
      for (int k = 0; k < NP; k++) begin
        if (unit == 4'(k)) begin
          case (rsel)
            io_port_pkg::REG_CTRL: ctrl_r[k] <= wdata[10:0];
            io_port_pkg::REG_COND: cond_r[k] <= wdata;
            io_port_pkg::REG_TIME: time_r[k] <= wdata[15:0]; // R8
            default: ;
          endcase
        end
      end
      if (unit == io_port_pkg::UNIT_GLOBAL
          && rsel == io_port_pkg::REG_LINK) begin
        link_en_r <= wdata[0];
      end
    end
  end

  // Block 0 stays on the reference clock; its fields cannot be written
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int b = 0; b < NC; b++) begin
        cb_src_r[b] <= 1'b0;
        cb_div_r[b] <= io_port_pkg::DIV_RESET;
      end
    end else if (wr && unit == io_port_pkg::UNIT_CB) begin
      for (int b = 1; b < NC; b++) begin
        if (rsel == 3'(b)) begin
          cb_src_r[b] <= wdata[io_port_pkg::CB_SRC]; // R15
          cb_div_r[b] <= wdata[io_port_pkg::CB_DIV_LO +: 8]; // R16
        end
      end
    end
  end

  always_comb begin
    for (int k = 0; k < NP; k++) begin
      wr_data[k] = wr && unit == 4'(k) && rsel == io_port_pkg::REG_DATA;
      rd_data[k] = rd && unit == 4'(k) && rsel == io_port_pkg::REG_DATA;
    end
  end

  clk_blk_if cbi ();
  assign cbi.src_pin = cb_src_r;
  assign cbi.div     = cb_div_r;
  assign cbi.ext_clk = pins_s[0]; // R15
  assign tick        = cbi.tick;

  clock_blocks u_cb (
    .clock (clock),
    .rst_n (rst_n),
    .cb    (cbi)
  ); // R14

  for (genvar k = 0; k < NP; k++) begin : g_port
    localparam int PW = io_port_pkg::PORT_W[k];
    logic [PW-1:0] pv;
    logic [2:0]    csel;
    logic          ptick;
    port_ctrl_if #(.W(PW)) pif ();

    assign csel  = ctrl_r[k][io_port_pkg::CTRL_CLK_LO +: 3];
    assign ptick = (int'(csel) < NC) ? tick[csel] : 1'b0;
    assign pif.enable        = ctrl_r[k][io_port_pkg::CTRL_EN];
    assign pif.dir_out       = ctrl_r[k][io_port_pkg::CTRL_OUT]; // R2
    assign pif.cond_mode     = ctrl_r[k][io_port_pkg::CTRL_COND_LO +: 2];
    assign pif.timed         = ctrl_r[k][io_port_pkg::CTRL_TIMED];
    assign pif.strobe_in_en  = ctrl_r[k][io_port_pkg::CTRL_SIN];
    assign pif.strobe_out_en = ctrl_r[k][io_port_pkg::CTRL_SOUT];
    assign pif.cond_val      = cond_r[k][PW-1:0];
    assign pif.time_val      = time_r[k];
    assign pif.wr            = wr_data[k];
    assign pif.rd            = rd_data[k];
    assign pif.wdata         = wdata[PW-1:0]; // R13
    assign pdat[k]   = 32'(pif.rdata);
    assign pval[k]   = 32'(pv);
    assign pcnt[k]   = pif.count;
    assign pstm[k]   = pif.stamp;
    assign pempty[k] = pif.empty;
    assign pfull[k]  = pif.full;

    port_engine #(.W(PW)) u_eng (
      .clock      (clock),
      .rst_n      (rst_n),
      .tick       (ptick),
      .pin_in     (pins_s[PW-1:0]), // R1
      .ready_in   (ready_s[k]),
      .pin_val    (pv),
      .strobe_out (strobe_out[k]),
      .event_out  (event_out[k]), // R19
      .ctl        (pif)
    );
  end

  // Pin ownership: narrowest enabled port covering the pin wins
  always_comb begin
    int own;
    logic hit;
    own   = 0;
    hit   = 1'b0;
    out_c = '0;
    oe_c  = '0;
    for (int p = 0; p < io_port_pkg::NPIN; p++) begin
      own = 0;
      hit = 1'b0;
      for (int k = NP - 1; k >= 0; k--) begin
        if (ctrl_r[k][io_port_pkg::CTRL_EN]
            && p < io_port_pkg::PORT_W[k]) begin
          own = k; // R11
          hit = 1'b1; // R12
        end
      end
      if (link_en_r && p >= io_port_pkg::LINK_LO
          && p <= io_port_pkg::LINK_HI) begin
        hit = 1'b0; // R10
      end
      if (hit && ctrl_r[own][io_port_pkg::CTRL_OUT]) begin
        if (ctrl_r[own][io_port_pkg::CTRL_OD]) begin
          out_c[p] = 1'b0;
          oe_c[p]  = !pval[own][p]; // R5
        end else begin
          out_c[p] = pval[own][p];
          oe_c[p]  = 1'b1;
        end
      end
    end
  end

  // Registered pin drive keeps pad outputs glitch free
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      pin_out <= out_c;
      pin_oe  <= oe_c;
    end
  end

  // Read data stands one cycle after the strobe, never waits
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= '0; // R4
      if (rd) begin
        for (int k = 0; k < NP; k++) begin
          if (unit == 4'(k)) begin
            case (rsel)
              io_port_pkg::REG_CTRL:   rdata <= 32'(ctrl_r[k]);
              io_port_pkg::REG_DATA:   rdata <= pdat[k];
              io_port_pkg::REG_COND:   rdata <= cond_r[k];
              io_port_pkg::REG_TIME:   rdata <= 32'(time_r[k]);
              io_port_pkg::REG_COUNT:  rdata <= 32'(pcnt[k]); // R8
              io_port_pkg::REG_STAMP:  rdata <= 32'(pstm[k]); // R9
              io_port_pkg::REG_STATUS:
                rdata <= 32'({pfull[k], pempty[k]}); // R21
              default: rdata <= '0;
            endcase
          end
        end
        if (unit == io_port_pkg::UNIT_GLOBAL
            && rsel == io_port_pkg::REG_LINK) begin
          rdata <= 32'(link_en_r);
        end
        if (unit == io_port_pkg::UNIT_CB && int'(rsel) < NC) begin
          rdata <= {16'h0000, cb_div_r[rsel], 7'h00, cb_src_r[rsel]};
        end
      end
    end
  end
endmodule : timed_shift_serializer_io_port

// *** pkg/clk_blk_if.sv ***
`timescale 1ns/1ps
interface clk_blk_if;
  logic [io_port_pkg::NCB-1:0]  src_pin;
  logic [io_port_pkg::DIVW-1:0] div [io_port_pkg::NCB];
  logic                         ext_clk;
  logic [io_port_pkg::NCB-1:0]  tick;
  modport blocks (input src_pin, div, ext_clk, output tick);
  modport ctrl (output src_pin, div, ext_clk, input tick);
endinterface : clk_blk_if

// *** pkg/io_port_pkg.sv ***
package io_port_pkg;
  localparam int NPORT = 5;
  localparam int NPIN  = 32;
  localparam int NCB   = 6;
  localparam int CW    = 16;
  localparam int DIVW  = 8;
  localparam int CFGW  = 11;
  localparam int SYNCW = NPIN + NPORT;
  localparam int PORT_W [0:4] = '{1, 4, 8, 16, 32};
  // Link pin range, arbitrary placement inside the wide port
  localparam int LINK_LO = 16;
  localparam int LINK_HI = 25;
  // Address split: unit in addr[6:3], register in addr[2:0]
  localparam logic [3:0] UNIT_GLOBAL = 4'h5;
  localparam logic [3:0] UNIT_CB     = 4'h6;
  localparam logic [2:0] REG_CTRL    = 3'h0;
  localparam logic [2:0] REG_DATA    = 3'h1;
  localparam logic [2:0] REG_COND    = 3'h2;
  localparam logic [2:0] REG_TIME    = 3'h3;
  localparam logic [2:0] REG_COUNT   = 3'h4;
  localparam logic [2:0] REG_STAMP   = 3'h5;
  localparam logic [2:0] REG_STATUS  = 3'h6;
  localparam logic [2:0] REG_LINK    = 3'h0;
  // Control field positions
  localparam int CTRL_EN      = 0;
  localparam int CTRL_OUT     = 1;
  localparam int CTRL_OD      = 2;
  localparam int CTRL_CLK_LO  = 3;
  localparam int CTRL_COND_LO = 6;
  localparam int CTRL_TIMED   = 8;
  localparam int CTRL_SIN     = 9;
  localparam int CTRL_SOUT    = 10;
  localparam int CB_SRC       = 0;
  localparam int CB_DIV_LO    = 8;
  localparam int STAT_EMPTY   = 0;
  localparam int STAT_FULL    = 1;
  localparam logic [CFGW-1:0] CTRL_RESET = 11'h000;
  localparam logic [DIVW-1:0] DIV_RESET  = 8'h00;
  // Wait conditions
  localparam logic [1:0] COND_NONE = 2'h0;
  localparam logic [1:0] COND_EQ   = 2'h1;
  localparam logic [1:0] COND_NE   = 2'h2;
endpackage : io_port_pkg

// *** pkg/port_ctrl_if.sv ***
`timescale 1ns/1ps
interface port_ctrl_if #(parameter int W = 1);
  logic          enable;
  logic          dir_out;
  logic [1:0]    cond_mode;
  logic          timed;
  logic          strobe_in_en;
  logic          strobe_out_en;
  logic [W-1:0]  cond_val;
  logic [15:0]   time_val;
  logic          wr;
  logic          rd;
  logic [W-1:0]  wdata;
  logic [W-1:0]  rdata;
  logic          empty;
  logic          full;
  logic [15:0]   count;
  logic [15:0]   stamp;
  modport engine (input enable, dir_out, cond_mode, timed, strobe_in_en,
                  strobe_out_en, cond_val, time_val, wr, rd, wdata,
                  output rdata, empty, full, count, stamp);
  modport ctrl (output enable, dir_out, cond_mode, timed, strobe_in_en,
                strobe_out_en, cond_val, time_val, wr, rd, wdata,
                input rdata, empty, full, count, stamp);
endinterface : port_ctrl_if

// *** sim/pin_partner.sv ***
`timescale 1ns/1ps
module pin_partner (
  // Pins seen from outside
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  output logic      [31:0] pin_in,
  // Application side drive
  input  wire logic [31:0] drive_en,
  input  wire logic [31:0] drive_val,
  input  wire logic [4:0]  ready_lvl,
  output logic      [4:0]  ready_in
);
  // Undriven pins fall to the pull-down, never keep a stale level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive_en & drive_val);
  // Ready level held by the application, slow or prompt
  assign ready_in = ready_lvl;
endmodule : pin_partner

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic        clock, rst_n, wr, rd, hit;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, pin_in, pin_out, pin_oe, drive_en, drive_val;
  logic [31:0] v, c;
  logic [4:0]  ready_in, strobe_out, event_out, ready_lvl;
  int          failures, checks, n;
  // Wait mode, compare value, pin value, capture expected
  logic [1:0]  md [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
  logic [3:0]  cv [5] = '{4'h0, 4'h9, 4'h3, 4'h3, 4'h9};
  logic [3:0]  pv [5] = '{4'h6, 4'h3, 4'h3, 4'h3, 4'h3};
  logic        tk [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  timed_shift_serializer_io_port i_timed_shift_serializer_io_port (.clock(clock), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .ready_in(ready_in), .strobe_out(strobe_out), .event_out(event_out));
  pin_partner i_pin_partner (.pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in), .drive_en(drive_en), .drive_val(drive_val),
    .ready_lvl(ready_lvl), .ready_in(ready_in));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task automatic wreg(input logic [3:0] u, input logic [2:0] r,
                      input logic [31:0] d);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= {1'b0, u, r};
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wreg
  // Data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] u, input logic [2:0] r);
    @(posedge clock);
    rd   <= 1'b1;
    addr <= {1'b0, u, r};
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    v = rdata;
  endtask : rreg
  // Write, then read the same register with no gap between strobes
  task automatic wrreg(input logic [3:0] u, input logic [2:0] r,
                       input logic [31:0] d);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= {1'b0, u, r};
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    v = rdata;
  endtask : wrreg
  task automatic wait_strobe(input int k, input int lim);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (strobe_out[k] !== 1'b1 && n < lim);
    hit = (strobe_out[k] === 1'b1);
  endtask : wait_strobe
  task automatic need_strobe(input int k, input int lim);
    wait_strobe(k, lim);
    check("strobe", {31'h0, hit}, 32'h1);
    if (hit !== 1'b1)
      print_verdict();
  endtask : need_strobe
  initial begin
    rst_n     = 1'b0;
    wr        = 1'b0;
    rd        = 1'b0;
    addr      = 8'h00;
    wdata     = 32'h0;
    drive_en  = 32'h0;
    drive_val = 32'h0;
    ready_lvl = 5'h00;
    failures  = 0;
    checks    = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      rreg(k[3:0], 3'h0);
      check("ctrl reset", v, 32'h0);
    end
    wreg(4'h6, 3'h0, 32'h0000FF01);
    rreg(4'h6, 3'h0);
    check("block0", v, 32'h0);
    wrreg(4'h6, 3'h2, 32'h0000FF01);
    check("block2", v, 32'h0000FF01);
    wreg(4'h6, 3'h2, 32'h0);
    wreg(4'hC, 3'h1, 32'hFFFFFFFF);
    rreg(4'hC, 3'h1);
    check("unmapped", v, 32'h0);
    // Input port with each wait mode
    drive_en <= 32'hF;
    for (int i = 0; i < 5; i++) begin
      drive_val <= {28'h0, pv[i]};
      wreg(4'h1, 3'h0, 32'h0);
      wreg(4'h1, 3'h2, {28'h0, cv[i]});
      wreg(4'h1, 3'h0, {24'h0, md[i], 6'h01});
      hit = 1'b0;
      for (int j = 0; j < 12 && !hit; j++) begin
        rreg(4'h1, 3'h6);
        hit = (v[0] === 1'b0);
      end
      check("captured", {31'h0, hit}, {31'h0, tk[i]});
      rreg(4'h1, 3'h1);
      if (tk[i])
        check("in data", v, {28'h0, pv[i]});
    end
    wreg(4'h1, 3'h0, 32'h0);
    drive_en <= 32'h0;
    // Output held by ready, third word refused
    wreg(4'h0, 3'h0, 32'h00000603);
    wreg(4'h0, 3'h1, 32'h0);
    wreg(4'h0, 3'h1, 32'h1);
    wreg(4'h0, 3'h1, 32'h0);
    rreg(4'h0, 3'h6);
    check("full", {30'h0, v[1:0]}, 32'h2);
    wait_strobe(0, 10);
    check("held", {31'h0, hit}, 32'h0);
    ready_lvl <= 5'h1F;
    need_strobe(0, 20);
    check("event", {31'h0, event_out[0]}, 32'h1);
    @(negedge clock);
    check("pin first", {30'h0, pin_oe[0], pin_out[0]}, 32'h2);
    need_strobe(0, 20);
    @(negedge clock);
    check("pin second", {30'h0, pin_oe[0], pin_out[0]}, 32'h3);
    wait_strobe(0, 12);
    check("dropped", {31'h0, hit}, 32'h0);
    // Timed output on a wider port sharing pin 0
    wreg(4'h2, 3'h0, 32'h00000503);
    rreg(4'h2, 3'h4);
    c = v;
    rreg(4'h2, 3'h4);
    check("count step", v - c, 32'h2);
    c = {16'h0, v[15:0] + 16'h0028};
    wreg(4'h2, 3'h3, c);
    wreg(4'h2, 3'h1, 32'hFFFFFFA4);
    need_strobe(2, 60);
    check("late", {31'h0, n > 25}, 32'h1);
    @(negedge clock);
    check("shared pins", {24'h0, pin_out[7:0]}, 32'hA5);
    rreg(4'h2, 3'h5);
    check("stamp", v, c);
    rreg(4'h2, 3'h1);
    check("narrow data", v, 32'h000000A4);
    // Open drain on the unshared upper byte
    wreg(4'h3, 3'h0, 32'h00000407);
    wreg(4'h3, 3'h1, 32'h00005A00);
    need_strobe(3, 20);
    @(negedge clock);
    check("od oe", {24'h0, pin_oe[15:8]}, 32'hA5);
    check("od low", {24'h0, pin_out[15:8] & pin_oe[15:8]}, 32'h0);
    // Link takes its pins away from the wide port
    wreg(4'h4, 3'h0, 32'h00000403);
    wreg(4'h4, 3'h1, 32'hFFFFFFFF);
    need_strobe(4, 20);
    wreg(4'h5, 3'h0, 32'h1);
    repeat (2) @(negedge clock);
    check("link oe", {16'h0, pin_oe[31:16]}, 32'hFC00);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    check("oe after reset", pin_oe, 32'h0);
    print_verdict();
  end
endmodule : tb

// *** sim/timed_shift_serializer_io_port_checker.sv ***
`timescale 1ns/1ps
module port_checker (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // Register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // Pins and strobes
  input wire logic [31:0] pin_in,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [4:0]  ready_in,
  input wire logic [4:0]  strobe_out,
  input wire logic [4:0]  event_out
);
  logic       link_r;
  logic [8:0] cbw_r;
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Shadow of link enable, only the bus changes it
  always_ff @(posedge clock) begin
    if (!rst_n)
      link_r <= 1'b0;
    else if (wr && addr[6:0] == 7'h28)
      link_r <= wdata[0];
  end
  always_ff @(posedge clock) begin
    if (wr)
      cbw_r <= {wdata[15:8], wdata[0]};
  end
  a_read_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("rdata not zero without a read");
  a_reset_quiet: assert property ($rose(rst_n) |->
    pin_oe == 32'h0 && strobe_out == 5'h0 && event_out == 5'h0)
    else $error("outputs active right after reset");
  a_link_release: assert property (link_r && $past(link_r) |->
    pin_oe[25:16] == 10'h0) else $error("link pins still driven");
  a_strobe_event: assert property ((strobe_out & ~event_out) == 5'h0)
    else $error("strobe without scheduler event");
  a_block_readback: assert property ((wr && addr[6:3] == 4'h6
    && addr[2:0] != 3'h0 && addr[2:0] < 3'h6) ##1 (rd && $stable(addr))
    |=> rdata == {16'h0, cbw_r[8:1], 7'h0, cbw_r[0]})
    else $error("clock block readback wrong");
  a_unmapped_zero: assert property (rd && addr[6:3] > 4'h6
    |=> rdata == 32'h0) else $error("unmapped read not zero");
  a_block0_fixed: assert property (rd && addr[6:0] == 7'h30
    |=> rdata == 32'h0) else $error("clock block 0 altered");
  a_status_legal: assert property (rd && addr[2:0] == 3'h6
    && addr[6:3] < 4'h5 |=> rdata[31:2] == 30'h0 && rdata[1:0] != 2'h3)
    else $error("status both full and empty");
  a_port_width: assert property (rd && addr[6:0] == 7'h11
    |=> rdata[31:8] == 24'h0) else $error("narrow port upper bits set");
  c_strobe: cover property (|strobe_out);
  c_link: cover property (link_r && pin_oe[31:26] != 6'h0);
  c_readback: cover property (wr && addr[6:3] == 4'h6 ##1 rd);
endmodule : port_checker
bind timed_shift_serializer_io_port port_checker i_port_checker (
  .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .ready_in(ready_in), .strobe_out(strobe_out),
  .event_out(event_out));
